//--- hw/baud_divider.sv
`timescale 1ns/10ps
`default_nettype none
module baud_divider
  import spi_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [1:0] rate_sel,
  // enable
  output logic tick
);
  logic [7:0] cnt_r;
  logic [7:0] limit;

  assign limit = rate_divisor(rate_sel) - 8'h01;

  // ==========================================================
  // one pulse every divisor base cycles
  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- hw/shift_engine.sv
`timescale 1ns/10ps
`default_nettype none
module shift_engine
  import spi_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  shift_link_if.engine lnk
);
  typedef enum logic [0:0] {idle_s, shift_s} eng_state_t;
  eng_state_t state_r;
  logic tick;
  logic phase_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;

  baud_divider u_div (
    .clk(clk),
    .rst_b(rst_b),
    .run(state_r == shift_s),
    .rate_sel(lnk.rate_sel),
    .tick(tick)
  );

  assign lnk.busy = (state_r == shift_s);
  assign lnk.mosi = sh_r[7];

  // ==========================================================
  // shifter: edge each divisor ticks, so serial rate = base/(2*div)
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= idle_s;
      phase_r <= 1'b0;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      lnk.sck <= 1'b0;
      lnk.taken <= 1'b0;
      lnk.done <= 1'b0;
      lnk.rx_bits <= 8'h00;
    end else begin
      lnk.taken <= 1'b0;
      lnk.done <= 1'b0;
      case (state_r)
        idle_s: begin
          lnk.sck <= lnk.cpol;
          phase_r <= 1'b0;
          if (lnk.start) begin
            sh_r <= lnk.tx_bits;
            bit_r <= 4'h0;
            lnk.taken <= 1'b1;
            state_r <= shift_s;
          end
        end
        default: begin
          if (tick) begin
            lnk.sck <= ~lnk.sck;
            phase_r <= ~phase_r;
            if (!phase_r) begin
              lnk.rx_bits <= {lnk.rx_bits[6:0], lnk.miso};
            end else begin
              sh_r <= {sh_r[6:0], 1'b0};
              if (bit_r == 4'(bits_per_frame - 1)) begin
                lnk.done <= 1'b1;
                state_r <= idle_s;
              end else begin
                bit_r <= bit_r + 4'h1;
              end
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- hw/shift_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface shift_link_if;
  logic start;
  logic [7:0] tx_bits;
  logic [1:0] rate_sel;
  logic cpol;
  logic taken;
  logic done;
  logic [7:0] rx_bits;
  logic busy;
  logic sck;
  logic mosi;
  logic miso;
  modport ctrl (output start, tx_bits, rate_sel, cpol, miso,
    input taken, done, rx_bits, busy, sck, mosi);
  modport engine (input start, tx_bits, rate_sel, cpol, miso,
    output taken, done, rx_bits, busy, sck, mosi);
endinterface
`default_nettype wire

//--- hw/spi_regs_pkg.sv
`default_nettype none
package spi_regs_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] status_ctrl_off = 12'h004;
  localparam logic [11:0] data_port_off = 12'h008;
  localparam logic [11:0] irq_status_off = 12'h00C;
  localparam logic [11:0] irq_mask_off = 12'h010;
  // ==========================================================
  // control register fields
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_master_bit = 1;
  localparam int ctrl_cpol_bit = 2;
  localparam int ctrl_tx_irq_en_bit = 3;
  localparam logic [7:0] ctrl_reset = 8'h02;
  // ==========================================================
  // status and control register fields
  localparam int sc_rate_lo_bit = 0;
  localparam int sc_rate_hi_bit = 1;
  localparam int sc_fault_en_bit = 2;
  localparam int sc_tx_empty_bit = 3;
  localparam int sc_fault_bit = 4;
  localparam int sc_busy_bit = 5;
  // ==========================================================
  // interrupt status / mask fields
  localparam int irq_tx_empty_bit = 0;
  localparam int irq_fault_bit = 1;
  localparam int irq_done_bit = 2;
  localparam int irq_width = 3;
  // ==========================================================
  // baud divisors
  localparam logic [7:0] div_sel0 = 8'h02;
  localparam logic [7:0] div_sel1 = 8'h08;
  localparam logic [7:0] div_sel2 = 8'h20;
  localparam logic [7:0] div_sel3 = 8'h80;
  localparam int bits_per_frame = 8;

  function automatic logic [7:0] rate_divisor(input logic [1:0] sel);
    case (sel)
      2'b00: rate_divisor = div_sel0;
      2'b01: rate_divisor = div_sel1;
      2'b10: rate_divisor = div_sel2;
      default: rate_divisor = div_sel3;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- hw/spi_status_rate_and_data_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - writing the data port clears the transmit-empty flag
// - reset sets transmit-empty; one means empty
// - mode fault sets only with fault detect enabled; enable is read/write
// - clearing fault detect enable leaves the mode fault flag set
// - master without fault detect ignores select and frees the pin
// - fault detect enabled makes select an input, not general purpose
// - slave claims the select pin whenever enabled
// - slave without fault detect only stops mode fault setting
// - rate select 00,01,10,11 gives divisor 2,8,32,128
// - master serial clock is base clock over twice the divisor
// - rate select ignored in slave; reset clears it
// - data port write loads transmit, read returns receive
// - transmit and receive data are separate registers
// - handoff to shifter sets transmit-empty and may interrupt
// - fault: slave select high mid-transfer, master select low
// - master select one is master, reset sets it
module spi_status_rate_and_data_regs
  import spi_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  output logic sck_out,
  output logic sck_oe,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic select_b_in,
  output logic select_claimed,
  // interrupt
  output logic irq
);
  shift_link_if lnk();

  shift_engine u_eng (
    .clk(clk),
    .rst_b(rst_b),
    .lnk(lnk)
  );

  logic [7:0] ctrl_r;
  logic [1:0] rate_sel_r;
  logic fault_en_r;
  logic tx_empty_r;
  logic fault_r;
  logic [7:0] tx_data_r;
  logic [7:0] rx_data_r;
  logic tx_pend_r;
  logic start_r;
  logic [irq_width-1:0] irq_stat_r;
  logic [irq_width-1:0] irq_mask_r;
  logic sel_prev_r;
  logic slave_active_r;
  logic wr_acc;
  logic rd_acc;
  logic enabled;
  logic is_master;
  logic fault_evt;
  logic data_wr;
  logic [irq_width-1:0] irq_evt;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign enabled = ctrl_r[ctrl_enable_bit];
  assign is_master = ctrl_r[ctrl_master_bit];
  assign data_wr = wr_acc && (paddr == data_port_off);

  // ==========================================================
  // fault detection
  always_comb begin
    fault_evt = 1'b0;
    if (enabled && fault_en_r) begin
      if (is_master) begin
        fault_evt = !select_b_in;
      end else begin
        fault_evt = slave_active_r && select_b_in && !sel_prev_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_prev_r <= 1'b1;
      slave_active_r <= 1'b0;
    end else begin
      sel_prev_r <= select_b_in;
      if (!enabled || is_master || select_b_in) begin
        slave_active_r <= 1'b0;
      end else if (!select_b_in) begin
        slave_active_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= ctrl_reset;
      rate_sel_r <= 2'b00;
      fault_en_r <= 1'b0;
      irq_mask_r <= '0;
    end else if (wr_acc) begin
      if (paddr == ctrl_off) begin
        ctrl_r <= pwdata[7:0];
      end else if (paddr == status_ctrl_off) begin
        rate_sel_r <= {pwdata[sc_rate_hi_bit], pwdata[sc_rate_lo_bit]};
        fault_en_r <= pwdata[sc_fault_en_bit];
      end else if (paddr == irq_mask_off) begin
        irq_mask_r <= pwdata[irq_width-1:0];
      end
    end
  end

  // mode fault: set wins; cleared by control write after status read
  logic fault_seen_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fault_r <= 1'b0;
      fault_seen_r <= 1'b0;
    end else begin
      if (rd_acc && paddr == status_ctrl_off) begin
        fault_seen_r <= fault_r;
      end
      if (fault_evt) begin
        fault_r <= 1'b1;
      end else if (wr_acc && paddr == ctrl_off && fault_seen_r) begin
        fault_r <= 1'b0;
        fault_seen_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // transmit path
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_empty_r <= 1'b1;
      tx_data_r <= 8'h00;
      tx_pend_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (data_wr) begin
        tx_data_r <= pwdata[7:0];
        tx_empty_r <= 1'b0;
        tx_pend_r <= 1'b1;
      end else if (lnk.taken) begin
        tx_empty_r <= 1'b1;
        tx_pend_r <= 1'b0;
      end
      if (tx_pend_r && enabled && is_master && !lnk.busy && !start_r
          && !lnk.taken && !fault_r) begin
        start_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_data_r <= 8'h00;
    end else if (lnk.done) begin
      rx_data_r <= lnk.rx_bits;
    end
  end

  assign lnk.start = start_r;
  assign lnk.tx_bits = tx_data_r;
  assign lnk.rate_sel = is_master ? rate_sel_r : 2'b00;
  assign lnk.cpol = ctrl_r[ctrl_cpol_bit];
  assign lnk.miso = miso_in;

  // ==========================================================
  // interrupts
  always_comb begin
    irq_evt = '0;
    irq_evt[irq_tx_empty_bit] = lnk.taken && ctrl_r[ctrl_tx_irq_en_bit];
    irq_evt[irq_fault_bit] = fault_evt;
    irq_evt[irq_done_bit] = lnk.done;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_r <= '0;
    end else if (wr_acc && paddr == irq_status_off) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[irq_width-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // ==========================================================
  // apb read and outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == ctrl_off) begin
          prdata[7:0] <= ctrl_r;
        end else if (paddr == status_ctrl_off) begin
          prdata[sc_rate_lo_bit] <= rate_sel_r[0];
          prdata[sc_rate_hi_bit] <= rate_sel_r[1];
          prdata[sc_fault_en_bit] <= fault_en_r;
          prdata[sc_tx_empty_bit] <= tx_empty_r;
          prdata[sc_fault_bit] <= fault_r;
          prdata[sc_busy_bit] <= lnk.busy;
        end else if (paddr == data_port_off) begin
          prdata[7:0] <= rx_data_r;
        end else if (paddr == irq_status_off) begin
          prdata[irq_width-1:0] <= irq_stat_r;
        end else if (paddr == irq_mask_off) begin
          prdata[irq_width-1:0] <= irq_mask_r;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      select_claimed <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
      sck_out <= lnk.sck;
      sck_oe <= enabled && is_master;
      mosi_out <= lnk.mosi;
      select_claimed <= enabled && (!is_master || fault_en_r);
    end
  end

  // ==========================================================
  // checks
  property p_tx_empty_clear;
    @(posedge clk) disable iff (!rst_b)
    data_wr |=> !tx_empty_r;
  endproperty
  a_tx_empty_clear: assert property (p_tx_empty_clear) else $error("tx empty not cleared");

  property p_fault_gate;
    @(posedge clk) disable iff (!rst_b)
    (!fault_r && !fault_en_r) |=> !fault_r;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault set while disabled");

  property p_fault_hold;
    @(posedge clk) disable iff (!rst_b)
    (fault_r && !(wr_acc && paddr == ctrl_off)) |=> fault_r;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag lost");

  property p_select_claim;
    @(posedge clk) disable iff (!rst_b)
    (enabled && !is_master) |=> select_claimed;
  endproperty
  a_select_claim: assert property (p_select_claim) else $error("slave select not claimed");

  property p_master_free;
    @(posedge clk) disable iff (!rst_b)
    (enabled && is_master && !fault_en_r) |=> !select_claimed;
  endproperty
  a_master_free: assert property (p_master_free) else $error("select not freed");

  property p_handoff;
    @(posedge clk) disable iff (!rst_b)
    (lnk.taken && !data_wr) |=> tx_empty_r;
  endproperty
  a_handoff: assert property (p_handoff) else $error("tx empty not set on handoff");

  property p_data_split;
    @(posedge clk) disable iff (!rst_b)
    (data_wr && !lnk.done) |=> $stable(rx_data_r);
  endproperty
  a_data_split: assert property (p_data_split) else $error("rx changed by write");

  property p_master_fault;
    @(posedge clk) disable iff (!rst_b)
    (enabled && is_master && fault_en_r && !select_b_in) |=> fault_r;
  endproperty
  a_master_fault: assert property (p_master_fault) else $error("master fault missed");
endmodule
`default_nettype wire

//--- verification/spi_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_far_model (
  // serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_b,
  output logic miso,
  // reply and capture
  input wire logic [7:0] reply,
  output logic [7:0] got
);
  logic [7:0] sh = 8'h00;
  logic [2:0] rcnt = 3'h0;
  // ==========================================
  // capture msb first on rising edges
  always @(posedge sck) begin
    sh = {sh[6:0], mosi};
    rcnt = rcnt + 3'h1;
    if (rcnt == 3'h0) begin
      got = sh;
    end
  end
  // reply bit follows the rising edge count, msb first
  // deselected line shows the inverse
  assign miso = sel_b ? ~reply[3'h7 - rcnt] : reply[3'h7 - rcnt];
endmodule
`default_nettype wire

//--- verification/spi_status_rate_and_data_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spi_status_rate_and_data_regs_bench;
  import spi_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sck_out, sck_oe, mosi_out, miso_in, select_claimed, irq;
  logic select_b_in = 1'b0;
  logic [7:0] reply = 8'h00;
  logic [7:0] got;
  int n_fail = 0;
  int samples_checked = 0;
  int divs [4] = '{2, 8, 32, 128};
  always #5 clk = ~clk;
  spi_status_rate_and_data_regs dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_out(mosi_out), .miso_in(miso_in), .select_b_in(select_b_in),
    .select_claimed(select_claimed), .irq(irq));
  spi_far_model far (.sck(sck_out), .mosi(mosi_out), .sel_b(select_b_in),
    .miso(miso_in), .reply(reply), .got(got));
  // ==========================================
  // bus and helpers
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_bit(input int b, input logic v);
    int i;
    i = 0;
    do begin
      apb(1'b0, status_ctrl_off, 32'h0000_0000);
      i++;
    end while (rd[b] !== v && i < 2000);
    if (rd[b] !== v) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic half_period(output int n);
    logic s;
    int i;
    s = sck_out;
    i = 0;
    while (sck_out === s && i < 600) begin
      @(posedge clk);
      i++;
    end
    s = sck_out;
    n = 0;
    while (sck_out === s && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (i >= 600 || n >= 600) begin
      n_fail++;
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    apb(1'b0, ctrl_off, 32'h0000_0000);
    `CHK(rd, 32'h0000_0002)
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd, 32'h0000_0008)
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("test reset done");
  endtask
  task automatic t_xfer(input logic [1:0] sel, input logic [7:0] a, input logic [7:0] b);
    int n;
    reply <= ~b;
    apb(1'b1, ctrl_off, 32'h0000_000B);
    apb(1'b1, status_ctrl_off, {30'h0, sel});
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[1:0], sel)
    apb(1'b1, data_port_off, {24'h0, a});
    half_period(n);
    `CHK(n[31:0], divs[sel])
    wait_bit(sc_tx_empty_bit, 1'b1);
    apb(1'b1, data_port_off, {24'h0, b});
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[sc_tx_empty_bit], 1'b0)
    wait_bit(sc_tx_empty_bit, 1'b1);
    wait_bit(sc_busy_bit, 1'b0);
    `CHK(sck_out, 1'b0)
    `CHK(sck_oe, 1'b1)
    apb(1'b0, data_port_off, 32'h0000_0000);
    `CHK(rd, {24'h0, ~b})
    `CHK(got, b)
    $display("test transfer rate %0d done", sel);
  endtask
  task automatic t_irq;
    apb(1'b1, irq_status_off, 32'h0000_0007);
    apb(1'b1, irq_mask_off, 32'h0000_0004);
    t_xfer(2'b00, 8'hA5, 8'h3C);
    `CHK(irq, 1'b1)
    apb(1'b0, irq_status_off, 32'h0000_0000);
    `CHK(rd, 32'h0000_0005)
    apb(1'b1, irq_status_off, 32'h0000_0004);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, irq_mask_off, 32'h0000_0000);
    $display("test interrupt done");
  endtask
  task automatic t_fault;
    apb(1'b1, status_ctrl_off, 32'h0000_0000);
    apb(1'b1, irq_mask_off, 32'h0000_0002);
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[sc_fault_bit], 1'b0)
    `CHK(select_claimed, 1'b0)
    apb(1'b1, status_ctrl_off, 32'h0000_0004);
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[sc_fault_bit], 1'b1)
    `CHK(rd[sc_fault_en_bit], 1'b1)
    `CHK(select_claimed, 1'b1)
    `CHK(irq, 1'b1)
    select_b_in <= 1'b1;
    apb(1'b1, status_ctrl_off, 32'h0000_0000);
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[sc_fault_bit], 1'b1)
    apb(1'b1, ctrl_off, 32'h0000_0001);
    select_b_in <= 1'b0;
    apb(1'b1, irq_status_off, 32'h0000_0002);
    select_b_in <= 1'b1;
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[sc_fault_bit], 1'b0)
    `CHK(select_claimed, 1'b1)
    `CHK(sck_oe, 1'b0)
    `CHK(irq, 1'b0)
    apb(1'b1, status_ctrl_off, 32'h0000_0004);
    select_b_in <= 1'b0;
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[sc_fault_bit], 1'b0)
    select_b_in <= 1'b1;
    apb(1'b0, status_ctrl_off, 32'h0000_0000);
    `CHK(rd[sc_fault_bit], 1'b1)
    `CHK(irq, 1'b1)
    $display("test fault done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_irq();
    for (int s = 1; s < 4; s++) begin
      t_xfer(s[1:0], 8'h81, 8'h4E);
    end
    t_fault();
    end_sim();
  end
endmodule
`default_nettype wire
